/* File: adcs_top.sv */
/*
 * Control and result logic around a single successive approximation
 * converter with four multiplexed inputs. Assumes the analog converter sits
 * outside, delivers its 12-bit code on ANALOG_RESULT, and that the register
 * master follows the one-cycle strobe protocol on MCLK.
 */
`timescale 1ns/100ps
`default_nettype none
module adcs_top (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [11:0] ANALOG_RESULT,
    output logic [3:0] ANALOG_PIN_EN,
    output logic [1:0] CONV_CHANNEL,
    output logic CONV_POWER_ON,
    output logic CONV_RESET,
    output logic CONV_CLK_TICK,
    output logic IRQ
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic start_bit;
    logic busy;
    logic [3:0] pin_function_bits;
    logic [1:0] channel_select;
    logic test_bit;
    logic module_power_off;
    logic [2:0] conv_clock_divider;
    logic [7:0] res_high;
    logic [3:0] res_low;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [11:0] result_meta;
    logic [11:0] result_sync;
    adcs_pkg::adcs_state_type state;
    adcs_pkg::adcs_state_type next_state;
    logic next_busy;
    logic [7:0] next_rdata;
    logic [7:0] next_irq_status;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire wr_ctrl = WR && ADDR == adcs_pkg::OFF_CONTROL;
    wire wr_cp = WR && ADDR == adcs_pkg::OFF_CLK_POWER;
    wire wr_mask = WR && ADDR == adcs_pkg::OFF_IRQ_MASK;
    wire rd_status = RD && ADDR == adcs_pkg::OFF_IRQ_STATUS;
    wire start_w = WDATA[adcs_pkg::CTRL_START_BIT];
    wire start_set = wr_ctrl && start_w;
    wire start_clr = wr_ctrl && !start_w;
    // Halt plays no part here on purpose
    wire conv_on = (pin_function_bits != 4'h0) && !module_power_off;
    wire tick;
    wire done;
    wire capture = state == adcs_pkg::ST_CONV && done && !start_set;
    wire conv_end = state == adcs_pkg::ST_FINISH && next_state == adcs_pkg::ST_IDLE;
    wire [7:0] irq_set = {7'h00, conv_end};
    wire [7:0] ctrl_view = {start_bit, busy, pin_function_bits, channel_select};
    wire [7:0] cp_view = {test_bit, module_power_off, 3'h0, conv_clock_divider};
    wire [7:0] low_view = {res_low, 4'h0};

    // ----------------------------------------------------------------
    // Clock divider and conversion timer
    // ----------------------------------------------------------------
    adcs_clk_div u_div (
        .clk(MCLK),
        .srst(SRST),
        .enable(conv_on && state == adcs_pkg::ST_CONV),
        .code(conv_clock_divider),
        .tick(tick)
    );

    adcs_conv_timer u_timer (
        .clk(MCLK),
        .srst(SRST),
        .clear(state != adcs_pkg::ST_CONV),
        .tick(tick),
        .done(done)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // A new start always wins, even on the cycle the conversion completes,
    // because software holding start high expects the converter in reset.
    always_comb begin
        next_state = state;
        case (state)
            adcs_pkg::ST_IDLE: begin
                if (start_set) begin
                    next_state = adcs_pkg::ST_HOLD;
                end
            end
            adcs_pkg::ST_HOLD: begin
                if (start_clr) begin
                    next_state = adcs_pkg::ST_CONV;
                end
            end
            adcs_pkg::ST_CONV: begin
                if (start_set) begin
                    next_state = adcs_pkg::ST_HOLD;
                end else if (done) begin
                    next_state = adcs_pkg::ST_FINISH;
                end
            end
            adcs_pkg::ST_FINISH: begin
                if (start_set) begin
                    next_state = adcs_pkg::ST_HOLD;
                end else begin
                    next_state = adcs_pkg::ST_IDLE;
                end
            end
            default: next_state = adcs_pkg::ST_IDLE;
        endcase
    end

    // Busy falls only on leaving the finish state, one cycle after capture
    assign next_busy = (next_state != adcs_pkg::ST_IDLE) ? 1'b1 :
        (conv_end ? 1'b0 : busy);

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state <= adcs_pkg::ST_IDLE;
            busy <= adcs_pkg::RST_BUSY;
            CONV_RESET <= 1'b0;
        end else begin
            state <= next_state;
            busy <= next_busy;
            CONV_RESET <= next_state == adcs_pkg::ST_HOLD;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            start_bit <= adcs_pkg::RST_START;
            pin_function_bits <= adcs_pkg::RST_PIN_BITS;
            channel_select <= adcs_pkg::RST_CHANNEL;
        end else if (wr_ctrl) begin
            start_bit <= start_w;
            pin_function_bits <= WDATA[adcs_pkg::CTRL_PIN_MSB:adcs_pkg::CTRL_PIN_LSB];
            channel_select <= WDATA[adcs_pkg::CTRL_CH_MSB:adcs_pkg::CTRL_CH_LSB];
        end
    end

    // The test bit is stored as written; software is expected to keep it
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            test_bit <= adcs_pkg::RST_TEST;
            module_power_off <= adcs_pkg::RST_POWER_OFF;
            conv_clock_divider <= adcs_pkg::RST_DIVIDER;
        end else if (wr_cp) begin
            test_bit <= WDATA[adcs_pkg::CP_TEST_BIT];
            module_power_off <= WDATA[adcs_pkg::CP_POWER_OFF_BIT];
            conv_clock_divider <= WDATA[adcs_pkg::CP_DIV_MSB:adcs_pkg::CP_DIV_LSB];
        end
    end

    // ----------------------------------------------------------------
    // Result capture
    // ----------------------------------------------------------------
    // The code is held stable by the converter at the end of conversion, so
    // a plain two-stage synchroniser on each bit is enough.
    always_ff @(posedge MCLK) begin
        result_meta <= ANALOG_RESULT;
        result_sync <= result_meta;
    end

    // Result bytes have no reset, their contents are undefined until the
    // first conversion completes.
    always_ff @(posedge MCLK) begin
        if (capture) begin
            res_high <= result_sync[11:4];
            res_low <= result_sync[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status and mask
    // ----------------------------------------------------------------
    assign next_irq_status = (irq_status & ~(rd_status ? 8'hFF : 8'h00)) | irq_set;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            irq_status <= adcs_pkg::RST_IRQ;
            irq_mask <= adcs_pkg::RST_IRQ;
            IRQ <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            if (wr_mask) begin
                irq_mask <= WDATA;
            end
            IRQ <= (irq_status & irq_mask) != 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Read port and pin side outputs
    // ----------------------------------------------------------------
    assign next_rdata = !RD ? 8'h00 :
        (ADDR == adcs_pkg::OFF_RES_HIGH) ? res_high :
        (ADDR == adcs_pkg::OFF_RES_LOW) ? low_view :
        (ADDR == adcs_pkg::OFF_CONTROL) ? ctrl_view :
        (ADDR == adcs_pkg::OFF_CLK_POWER) ? cp_view :
        (ADDR == adcs_pkg::OFF_IRQ_STATUS) ? irq_status :
        (ADDR == adcs_pkg::OFF_IRQ_MASK) ? irq_mask : 8'h00;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            RDATA <= 8'h00;
            ANALOG_PIN_EN <= adcs_pkg::RST_PIN_BITS;
            CONV_CHANNEL <= adcs_pkg::RST_CHANNEL;
            CONV_POWER_ON <= 1'b0;
            CONV_CLK_TICK <= 1'b0;
        end else begin
            RDATA <= next_rdata;
            ANALOG_PIN_EN <= pin_function_bits;
            CONV_CHANNEL <= channel_select;
            CONV_POWER_ON <= conv_on;
            // Ticks past the last counted period are held back, so the converter
            // sees exactly the fixed conversion length at every ratio
            CONV_CLK_TICK <= tick && state == adcs_pkg::ST_CONV && !done;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_low_nibble_zero: assert property (@(posedge MCLK) disable iff (SRST)
        (RD && ADDR == adcs_pkg::OFF_RES_LOW) |=> RDATA[3:0] == 4'h0)
        else $error("low result nibble not zero");

    chk_cp_gap_zero: assert property (@(posedge MCLK) disable iff (SRST)
        (RD && ADDR == adcs_pkg::OFF_CLK_POWER) |=> RDATA[5:3] == 3'h0)
        else $error("clock register gap bits not zero");

    chk_start_holds: assert property (@(posedge MCLK) disable iff (SRST)
        start_bit |-> busy && CONV_RESET)
        else $error("start high without reset and busy");

    chk_start_launch: assert property (@(posedge MCLK) disable iff (SRST)
        $fell(start_bit) && $past(state) == adcs_pkg::ST_HOLD |-> state == adcs_pkg::ST_CONV)
        else $error("start release did not launch conversion");

    chk_result_first: assert property (@(posedge MCLK) disable iff (SRST)
        $fell(busy) |-> $past(state) == adcs_pkg::ST_FINISH
        && {res_high, res_low} == $past(result_sync, 2))
        else $error("busy fell before result stored");

    chk_end_flag: assert property (@(posedge MCLK) disable iff (SRST)
        $fell(busy) |-> irq_status[adcs_pkg::IRQ_DONE_BIT])
        else $error("conversion end did not set flag");

    chk_irq_follow: assert property (@(posedge MCLK) disable iff (SRST)
        ((irq_status & irq_mask) != 8'h00) |=> IRQ)
        else $error("unmasked flag without interrupt");

    chk_pins_off: assert property (@(posedge MCLK) disable iff (SRST)
        (pin_function_bits == 4'h0) |=> !CONV_POWER_ON && ANALOG_PIN_EN == 4'h0)
        else $error("converter on with no analog pins");

    chk_power_bit: assert property (@(posedge MCLK) disable iff (SRST)
        module_power_off |=> !CONV_POWER_ON)
        else $error("converter on while powered off");

    chk_tick_in_conv: assert property (@(posedge MCLK) disable iff (SRST)
        CONV_CLK_TICK |-> $past(state) == adcs_pkg::ST_CONV && !$past(done))
        else $error("converter tick outside conversion");

    chk_channel_route: assert property (@(posedge MCLK) disable iff (SRST)
        wr_ctrl |-> ##2 CONV_CHANNEL
        == $past(WDATA[adcs_pkg::CTRL_CH_MSB:adcs_pkg::CTRL_CH_LSB], 2))
        else $error("channel field not routed");

    chk_pin_route: assert property (@(posedge MCLK) disable iff (SRST)
        wr_ctrl |-> ##2 ANALOG_PIN_EN
        == $past(WDATA[adcs_pkg::CTRL_PIN_MSB:adcs_pkg::CTRL_PIN_LSB], 2))
        else $error("pin function bits not routed");

    chk_busy_on_start: assert property (@(posedge MCLK) disable iff (SRST)
        start_set |=> busy && start_bit)
        else $error("start write did not raise busy");

    chk_launch_release: assert property (@(posedge MCLK) disable iff (SRST)
        (start_clr && state == adcs_pkg::ST_HOLD) |=> !CONV_RESET && busy
        && state == adcs_pkg::ST_CONV)
        else $error("start release left converter in reset");

    chk_end_set_wins: assert property (@(posedge MCLK) disable iff (SRST)
        conv_end |=> irq_status[adcs_pkg::IRQ_DONE_BIT] && !busy)
        else $error("conversion end lost its flag");
endmodule
`default_nettype wire

/* File: adcs_pkg.sv */
/*
 * Constants shared by the converter control sequencer: register offsets,
 * field positions, reset values, clock divider codes and the conversion length.
 * Assumes a byte-wide register port and a single 25 MHz system clock.
 */
// How it works
// - One converter serves four analog inputs and each finished conversion gives a 12-bit unsigned result.
// - Result bits 11..4 fill the high result byte and bits 3..0 sit in bits 7..4 of the low byte, both read only.
// - Bits 3..0 of the low result byte and bits 5..3 of the clock and power register always read zero.
// - Writing the start bit high and then low again launches one conversion on the selected input.
// - While the start bit stays high the converter is held in reset and the busy flag reads one.
// - The read-only busy flag in bit 6 is high while a conversion runs, low once it ends, and one after reset.
// - Each pin function bit set to one turns its shared pin into an analog input, zero leaves it a plain pin.
// - With all four pin function bits zero the converter is powered off and every pin stays ordinary I/O.
// - The two-bit channel field picks input 0, 1, 2 or 3 for codes 00, 01, 10 and 11.
// - The power-off bit, reset to zero, keeps the converter powered when zero and powers it down when one.
// - The clock field divides the system clock by 2, 8, 32, 1, 4 or 16 for codes 000, 001, 010, 100, 101, 110.
// - The end of a conversion sets an interrupt flag that raises the interrupt when enabled.
// - Only the power-off bit and the pin function bits decide whether the converter is on; halt has no say.
package adcs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFF_RES_HIGH = 3'h0;
    localparam logic [2:0] OFF_RES_LOW = 3'h1;
    localparam logic [2:0] OFF_CONTROL = 3'h2;
    localparam logic [2:0] OFF_CLK_POWER = 3'h3;
    localparam logic [2:0] OFF_IRQ_STATUS = 3'h4;
    localparam logic [2:0] OFF_IRQ_MASK = 3'h5;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_START_BIT = 7;
    localparam int CTRL_BUSY_BIT = 6;
    localparam int CTRL_PIN_MSB = 5;
    localparam int CTRL_PIN_LSB = 2;
    localparam int CTRL_CH_MSB = 1;
    localparam int CTRL_CH_LSB = 0;
    localparam int CP_TEST_BIT = 7;
    localparam int CP_POWER_OFF_BIT = 6;
    localparam int CP_DIV_MSB = 2;
    localparam int CP_DIV_LSB = 0;
    localparam int IRQ_DONE_BIT = 0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic RST_START = 1'b0;
    localparam logic RST_BUSY = 1'b1;
    localparam logic [3:0] RST_PIN_BITS = 4'h0;
    localparam logic [1:0] RST_CHANNEL = 2'h0;
    localparam logic RST_TEST = 1'b1;
    localparam logic RST_POWER_OFF = 1'b0;
    localparam logic [2:0] RST_DIVIDER = 3'h0;
    localparam logic [7:0] RST_IRQ = 8'h00;

    // ----------------------------------------------------------------
    // Converter clock divider codes, ratio minus one
    // ----------------------------------------------------------------
    localparam logic [2:0] DIV_CODE_2 = 3'h0;
    localparam logic [2:0] DIV_CODE_8 = 3'h1;
    localparam logic [2:0] DIV_CODE_32 = 3'h2;
    localparam logic [2:0] DIV_CODE_1 = 3'h4;
    localparam logic [2:0] DIV_CODE_4 = 3'h5;
    localparam logic [2:0] DIV_CODE_16 = 3'h6;
    localparam logic [4:0] DIV_M1_2 = 5'h01;
    localparam logic [4:0] DIV_M1_8 = 5'h07;
    localparam logic [4:0] DIV_M1_32 = 5'h1F;
    localparam logic [4:0] DIV_M1_1 = 5'h00;
    localparam logic [4:0] DIV_M1_4 = 5'h03;
    localparam logic [4:0] DIV_M1_16 = 5'h0F;

    // ----------------------------------------------------------------
    // Conversion length in converter clock periods
    // ----------------------------------------------------------------
    localparam logic [4:0] CONV_PERIODS = 5'h10;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_CONV = 4'b0100,
        ST_FINISH = 4'b1000
    } adcs_state_type;

endpackage

/* File: adcs_clk_div.sv */
/*
 * Converter clock divider: turns the system clock into a one-cycle tick at
 * the selected ratio. Assumes the code is a register on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module adcs_clk_div (
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic [2:0] code,
    output logic tick
);
    logic [4:0] cnt;
    logic [4:0] ratio_m1;
    logic code_ok;

    // Undefined codes stop the tick, so a conversion stalls instead of running
    // at a guessed rate.
    always_comb begin
        ratio_m1 = adcs_pkg::DIV_M1_2;
        code_ok = 1'b1;
        case (code)
            adcs_pkg::DIV_CODE_2: ratio_m1 = adcs_pkg::DIV_M1_2;
            adcs_pkg::DIV_CODE_8: ratio_m1 = adcs_pkg::DIV_M1_8;
            adcs_pkg::DIV_CODE_32: ratio_m1 = adcs_pkg::DIV_M1_32;
            adcs_pkg::DIV_CODE_1: ratio_m1 = adcs_pkg::DIV_M1_1;
            adcs_pkg::DIV_CODE_4: ratio_m1 = adcs_pkg::DIV_M1_4;
            adcs_pkg::DIV_CODE_16: ratio_m1 = adcs_pkg::DIV_M1_16;
            default: code_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst || !enable || !code_ok) begin
            cnt <= 5'h00;
            tick <= 1'b0;
        end else if (cnt >= ratio_m1) begin
            cnt <= 5'h00;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 5'h01;
            tick <= 1'b0;
        end
    end

    chk_div4_spacing: assert property (@(posedge clk) disable iff (srst)
        (tick && code == adcs_pkg::DIV_CODE_4 && enable)
        ##1 (code == adcs_pkg::DIV_CODE_4 && enable) [*3] |-> !tick)
        else $error("divide by 4 tick came early");

    chk_div1_every: assert property (@(posedge clk) disable iff (srst)
        (enable && code == adcs_pkg::DIV_CODE_1)
        ##1 (enable && code == adcs_pkg::DIV_CODE_1) |-> tick)
        else $error("undivided tick missing");
endmodule
`default_nettype wire

/* File: adcs_conv_timer.sv */
/*
 * Conversion timer: counts converter clock ticks and pulses done after the
 * fixed conversion length. Assumes clear is held outside a conversion.
 */
`timescale 1ns/100ps
`default_nettype none
module adcs_conv_timer (
    input wire logic clk,
    input wire logic srst,
    input wire logic clear,
    input wire logic tick,
    output logic done
);
    logic [4:0] count;

    always_ff @(posedge clk) begin
        if (srst || clear) begin
            count <= 5'h00;
            done <= 1'b0;
        end else if (tick && count == adcs_pkg::CONV_PERIODS - 5'h01) begin
            count <= 5'h00;
            done <= 1'b1;
        end else if (tick) begin
            count <= count + 5'h01;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
        end
    end

    chk_done_single: assert property (@(posedge clk) disable iff (srst)
        done |=> !done)
        else $error("done pulse longer than one cycle");
endmodule
`default_nettype wire

/* File: adcs_top_bench.sv */
/*
 * Self-checking bench for the converter control sequencer top level.
 * Assumes the package and design files are compiled first; the bench is the
 * register master and also plays the analog converter on ANALOG_RESULT.
 */
`timescale 1ns/100ps
`default_nettype none
module adcs_top_bench;

    // ----------------------------------------------------------------
    // Signals and design instance
    // ----------------------------------------------------------------
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [11:0] analog_result = 12'h000;
    logic [7:0] rdata;
    logic [3:0] analog_pin_en;
    logic [1:0] conv_channel;
    logic conv_power_on;
    logic conv_reset;
    logic conv_clk_tick;
    logic irq;
    int miscompares = 0;
    int tests_run = 0;

    adcs_top i_dut (
        .MCLK(mclk),
        .SRST(srst),
        .ADDR(addr),
        .WDATA(wdata),
        .WR(wr),
        .RD(rd),
        .RDATA(rdata),
        .ANALOG_RESULT(analog_result),
        .ANALOG_PIN_EN(analog_pin_en),
        .CONV_CHANNEL(conv_channel),
        .CONV_POWER_ON(conv_power_on),
        .CONV_RESET(conv_reset),
        .CONV_CLK_TICK(conv_clk_tick),
        .IRQ(irq)
    );

    always #20 mclk = ~mclk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        tests_run++;
        if (seen !== expected) begin
            miscompares++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, expected);
        end
    endtask

    task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic bus_read_check(input logic [2:0] a, input logic [7:0] expected);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check(rdata, expected);
    endtask

    task automatic print_verdict;
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic reset_values;
        #1;
        check({conv_power_on, analog_pin_en, conv_reset, irq}, 16'h0000);
        bus_read_check(adcs_pkg::OFF_CONTROL, 8'h40);
        bus_read_check(adcs_pkg::OFF_CLK_POWER, 8'h80);
        bus_read_check(adcs_pkg::OFF_IRQ_STATUS, 8'h00);
        bus_read_check(3'h6, 8'h00);
        // Reserved bits of the clock register ignore ones written to them
        bus_write(adcs_pkg::OFF_CLK_POWER, 8'hFF);
        bus_read_check(adcs_pkg::OFF_CLK_POWER, 8'hC7);
        bus_write(adcs_pkg::OFF_RES_HIGH, 8'h5A);
        bus_write(adcs_pkg::OFF_CLK_POWER, 8'h80);
    endtask

    task automatic power_and_pins;
        bus_write(adcs_pkg::OFF_CONTROL, 8'h14);
        repeat (3) @(posedge mclk);
        check({analog_pin_en, conv_power_on}, {4'h5, 1'b1});
        bus_write(adcs_pkg::OFF_CLK_POWER, 8'hC0);
        repeat (3) @(posedge mclk);
        check(conv_power_on, 1'b0);
        bus_write(adcs_pkg::OFF_CLK_POWER, 8'h80);
        bus_write(adcs_pkg::OFF_CONTROL, 8'h03);
        repeat (3) @(posedge mclk);
        check({analog_pin_en, conv_power_on, conv_channel}, {4'h0, 1'b0, 2'h3});
    endtask

    // One conversion at a divider code, timed by the converter clock ticks
    task automatic convert(input logic [2:0] code, input int ratio, input logic [1:0] ch,
                           input logic [11:0] res, input logic mask);
        int ticks;
        int first;
        int last;
        ticks = 0;
        first = 0;
        last = 0;
        bus_write(adcs_pkg::OFF_IRQ_MASK, {7'h00, mask});
        bus_write(adcs_pkg::OFF_CLK_POWER, {5'h10, code});
        analog_result <= res;
        bus_write(adcs_pkg::OFF_CONTROL, {2'b10, 4'hF, ch});
        bus_read_check(adcs_pkg::OFF_CONTROL, {2'b11, 4'hF, ch});
        check({conv_reset, conv_channel}, {1'b1, ch});
        bus_write(adcs_pkg::OFF_CONTROL, {2'b00, 4'hF, ch});
        for (int i = 0; i < 16 * ratio + 30; i++) begin
            @(posedge mclk);
            #1;
            if (conv_clk_tick === 1'b1) begin
                if (ticks == 0) begin
                    first = i;
                end
                last = i;
                ticks++;
            end
        end
        check(ticks, 16);
        check(last - first, 15 * ratio);
        check(irq, mask);
        check(conv_reset, 1'b0);
        bus_read_check(adcs_pkg::OFF_CONTROL, {2'b00, 4'hF, ch});
        bus_read_check(adcs_pkg::OFF_RES_HIGH, res[11:4]);
        bus_read_check(adcs_pkg::OFF_RES_LOW, {res[3:0], 4'h0});
        bus_read_check(adcs_pkg::OFF_IRQ_STATUS, 8'h01);
        bus_read_check(adcs_pkg::OFF_IRQ_STATUS, 8'h00);
        repeat (2) @(posedge mclk);
        check(irq, 1'b0);
    endtask

    task automatic all_dividers;
        logic [2:0] codes [6];
        int ratios [6];
        codes = '{3'h4, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2};
        ratios = '{1, 2, 4, 8, 16, 32};
        for (int i = 0; i < 6; i++) begin
            convert(codes[i], ratios[i], i[1:0], 12'hA53 ^ {i[3:0], i[3:0], i[3:0]}, 1'b1);
        end
        convert(3'h4, 1, 2'h2, 12'h3C9, 1'b0);
    endtask

    // Undefined divider code gives no converter clock, so busy stays high
    task automatic undefined_divider;
        int ticks;
        ticks = 0;
        bus_write(adcs_pkg::OFF_CLK_POWER, 8'h83);
        bus_write(adcs_pkg::OFF_CONTROL, 8'hBD);
        bus_write(adcs_pkg::OFF_CONTROL, 8'h3D);
        repeat (200) begin
            @(posedge mclk);
            #1;
            if (conv_clk_tick === 1'b1) begin
                ticks++;
            end
        end
        check(ticks, 0);
        bus_read_check(adcs_pkg::OFF_CONTROL, 8'h7D);
    endtask

    // Power-off before sleep, then a reset in mid-run while a conversion is stalled
    task automatic sleep_and_reset;
        bus_write(adcs_pkg::OFF_CLK_POWER, 8'hC3);
        repeat (2) @(posedge mclk);
        check(conv_power_on, 1'b0);
        srst <= 1'b1;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        check({conv_power_on, analog_pin_en, conv_reset, irq, conv_channel}, 16'h0000);
        bus_read_check(adcs_pkg::OFF_CONTROL, 8'h40);
        bus_read_check(adcs_pkg::OFF_CLK_POWER, 8'h80);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        reset_values();
        power_and_pins();
        all_dividers();
        undefined_divider();
        sleep_and_reset();
        print_verdict();
    end

    // Longest conversion set is about 1400 cycles; allow a wide margin
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        print_verdict();
    end

endmodule
`default_nettype wire
